// [bmru_pkg.sv]
// Purpose: shared constants and operation codes for the rotate / sign-extend / shift-add unit
// Assumes: 64-bit datapath; a 32-bit base is selected at run time by an input
// Notes: the unit's datapath widths, bit positions and shift counts live here

package bmru_pkg;

  localparam int XLEN = 64;
  localparam int WORD = 32;
  localparam int SHAMT_W = 6;
  localparam int WAMT_W = 5;
  localparam int SHAMT_HI = 5;       // shamt bit that is reserved on a 32-bit base
  localparam int WORD_MSB = 31;
  localparam int BYTE_MSB = 7;
  localparam int HALF_MSB = 15;
  localparam int SH_ONE = 1;
  localparam int SH_TWO = 2;
  localparam logic [XLEN-1:0] ZERO_X = 64'h0000_0000_0000_0000;
  localparam logic [WAMT_W-1:0] ONE_W = 5'h01;

  // operation select from decode
  typedef enum logic [3:0] {
    BMRU_ROLW,
    BMRU_ROR,
    BMRU_RORI,
    BMRU_RORIW,
    BMRU_RORW,
    BMRU_SEXTB,
    BMRU_SEXTH,
    BMRU_SH1ADD,
    BMRU_SH1ADDUW,
    BMRU_SH2ADD,
    BMRU_SH2ADDUW
  } bmru_op_t;

endpackage

// [bmru_rotr.sv]
// Purpose: combinational rotate right of a W-bit value
// Assumes: amount is below W
// Notes: rotate left is done by the caller with a negated amount

`timescale 1ns/10ps

module bmru_rotr #(
  parameter int W = 64,
  parameter int AW = 6
) (
  input wire logic [W-1:0] data_i,
  input wire logic [AW-1:0] amt_i,
  output logic [W-1:0] data_o
);

  logic [2*W-1:0] dbl;

  // doubled word shifted right, low half is the rotated value
  always_comb begin
    dbl = {data_i, data_i} >> amt_i;
    data_o = dbl[W-1:0];
  end

endmodule // bmru_rotr

// [bmru_unit.sv]
// Purpose: execute stage for word/full rotates, byte/half sign extension and shift-add
// Assumes: operands are stable and synchronous to clk_i; en_i freezes the stage
// Notes: result is registered at the end of the select cycle; base32_i selects a 32-bit base

`timescale 1ns/10ps

// Notes on behaviour
// - rolw rotates the low word of rs1 left by rs2[4:0] and sign-extends the word result.
// - ror rotates the low word of rs1 right by rs2[4:0] on a 32-bit base and the whole rs1 by rs2[5:0] on 64 bits.
// - rori rotates rs1 right by shamt on 64 bits and the low word by shamt[4:0] on a 32-bit base, where shamt[5] set is not a valid rotate.
// - roriw rotates the low word of rs1 right by shamt and sign-extends from bit 31.
// - rorw rotates the low word of rs1 right by rs2[4:0] and sign-extends from bit 31.
// - sext.b copies bit 7 of the low byte into every higher bit.
// - sext.h copies bit 15 of the low halfword into every higher bit.
// - sh1add adds rs1 shifted left by one to rs2 at full width on 64 bits and sign-extends the low word of the sum on a 32-bit base.
// - sh1add.uw adds the zero-extended low word of rs1 shifted left by one to rs2.
// - sh2add adds rs1 shifted left by two to rs2 at full width on 64 bits and sign-extends the low word of the sum on a 32-bit base.
// - sh2add.uw adds the zero-extended low word of rs1 shifted left by two to rs2.
module bmru_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic base32_i,
  input wire logic valid_i,
  input wire logic [3:0] op_i,
  input wire logic [bmru_pkg::XLEN-1:0] rs1_i,
  input wire logic [bmru_pkg::XLEN-1:0] rs2_i,
  input wire logic [bmru_pkg::SHAMT_W-1:0] shamt_i,
  output logic [bmru_pkg::XLEN-1:0] result_o,
  output logic valid_o,
  output logic illegal_o
);

  ////////////////////////////////////////////////////////////////////////////
  // rotators

  bmru_pkg::bmru_op_t op;
  logic [bmru_pkg::SHAMT_W-1:0] full_amt;
  logic [bmru_pkg::WAMT_W-1:0] word_amt;
  logic [bmru_pkg::XLEN-1:0] full_rot;
  logic [bmru_pkg::WORD-1:0] word_rot;

  // amount selection; left rotate is right rotate by the negated amount
  always_comb begin
    op = bmru_pkg::bmru_op_t'(op_i);
    full_amt = (op == bmru_pkg::BMRU_RORI) ? shamt_i : rs2_i[bmru_pkg::SHAMT_W-1:0];
    case (op)
      bmru_pkg::BMRU_ROLW: word_amt = ~rs2_i[bmru_pkg::WAMT_W-1:0] + bmru_pkg::ONE_W;
      bmru_pkg::BMRU_RORI,
      bmru_pkg::BMRU_RORIW: word_amt = shamt_i[bmru_pkg::WAMT_W-1:0];
      default: word_amt = rs2_i[bmru_pkg::WAMT_W-1:0];
    endcase
  end

  bmru_rotr #(.W(bmru_pkg::XLEN), .AW(bmru_pkg::SHAMT_W)) u_full (
    .data_i(rs1_i),
    .amt_i(full_amt),
    .data_o(full_rot)
  );

  bmru_rotr #(.W(bmru_pkg::WORD), .AW(bmru_pkg::WAMT_W)) u_word (
    .data_i(rs1_i[bmru_pkg::WORD_MSB:0]),
    .amt_i(word_amt),
    .data_o(word_rot)
  );

  ////////////////////////////////////////////////////////////////////////////
  // result selection

  logic [bmru_pkg::XLEN-1:0] res;
  logic [bmru_pkg::XLEN-1:0] uw;
  logic word_res;
  logic bad;
  logic [bmru_pkg::XLEN-1:0] result_next;
  logic valid_next;
  logic illegal_next;

  // combinational operation; word results and 32-bit base results sign-extend bit 31
  always_comb begin
    uw = {{bmru_pkg::WORD{1'b0}}, rs1_i[bmru_pkg::WORD_MSB:0]};
    res = bmru_pkg::ZERO_X;
    word_res = base32_i;
    bad = 1'b0;
    case (op)
      bmru_pkg::BMRU_ROLW,
      bmru_pkg::BMRU_RORIW,
      bmru_pkg::BMRU_RORW: begin
        res[bmru_pkg::WORD_MSB:0] = word_rot;
        word_res = 1'b1;
        bad = base32_i;
      end
      bmru_pkg::BMRU_ROR: begin
        res = base32_i ? {{bmru_pkg::WORD{1'b0}}, word_rot} : full_rot;
      end
      bmru_pkg::BMRU_RORI: begin
        res = base32_i ? {{bmru_pkg::WORD{1'b0}}, word_rot} : full_rot;
        bad = base32_i & shamt_i[bmru_pkg::SHAMT_HI];
      end
      bmru_pkg::BMRU_SEXTB: begin
        res = {{(bmru_pkg::XLEN-bmru_pkg::BYTE_MSB-1){rs1_i[bmru_pkg::BYTE_MSB]}},
               rs1_i[bmru_pkg::BYTE_MSB:0]};
      end
      bmru_pkg::BMRU_SEXTH: begin
        res = {{(bmru_pkg::XLEN-bmru_pkg::HALF_MSB-1){rs1_i[bmru_pkg::HALF_MSB]}},
               rs1_i[bmru_pkg::HALF_MSB:0]};
      end
      bmru_pkg::BMRU_SH1ADD: res = rs2_i + (rs1_i << bmru_pkg::SH_ONE);
      bmru_pkg::BMRU_SH2ADD: res = rs2_i + (rs1_i << bmru_pkg::SH_TWO);
      bmru_pkg::BMRU_SH1ADDUW: begin
        res = rs2_i + (uw << bmru_pkg::SH_ONE);
        bad = base32_i;
      end
      bmru_pkg::BMRU_SH2ADDUW: begin
        res = rs2_i + (uw << bmru_pkg::SH_TWO);
        bad = base32_i;
      end
      default: bad = 1'b1;
    endcase
    if (word_res) begin
      res[bmru_pkg::XLEN-1:bmru_pkg::WORD] = {bmru_pkg::WORD{res[bmru_pkg::WORD_MSB]}};
    end
    // a flagged encoding writes nothing back
    result_next = bad ? bmru_pkg::ZERO_X : res;
    valid_next = valid_i & ~bad;
    illegal_next = valid_i & bad;
  end

  // output registers, frozen while en_i is low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_o <= bmru_pkg::ZERO_X;
      valid_o <= 1'b0;
      illegal_o <= 1'b0;
    end else if (en_i) begin
      result_o <= result_next;
      valid_o <= valid_next;
      illegal_o <= illegal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic go;
  assign go = en_i & valid_i & ~base32_i;

  rolw_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_ROLW |=> result_o == {{32{result_o[31]}},
      32'(($past(rs1_i[31:0]) << $past(rs2_i[4:0]))
        | ({32'h0000_0000, $past(rs1_i[31:0])} >> (32 - $past(rs2_i[4:0]))))})
    else $error("rolw result wrong");

  ror_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_ROR |=> valid_o
      && result_o == (($past(rs1_i) >> $past(rs2_i[5:0]))
        | 64'({$past(rs1_i), 64'h0000_0000_0000_0000} >> $past(rs2_i[5:0]))))
    else $error("ror result wrong");

  rori_reserved_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && valid_i && base32_i && op == bmru_pkg::BMRU_RORI && shamt_i[5]
      |=> illegal_o && !valid_o)
    else $error("reserved rori not flagged");

  rori_full_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_RORI |=> !illegal_o
      && result_o == (($past(rs1_i) >> $past(shamt_i))
        | 64'({$past(rs1_i), 64'h0000_0000_0000_0000} >> $past(shamt_i))))
    else $error("rori result wrong");

  roriw_sign_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_RORIW |=> result_o[63:32] == {32{result_o[31]}}
      && result_o[31:0] == 32'({$past(rs1_i[31:0]), $past(rs1_i[31:0])}
        >> $past(shamt_i[4:0])))
    else $error("roriw result wrong");

  rorw_result_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_RORW |=> result_o[63:32] == {32{result_o[31]}}
      && result_o[31:0] == 32'({$past(rs1_i[31:0]), $past(rs1_i[31:0])}
        >> $past(rs2_i[4:0])))
    else $error("rorw result wrong");

  sextb_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && valid_i && op == bmru_pkg::BMRU_SEXTB
      |=> result_o == {{56{$past(rs1_i[7])}}, $past(rs1_i[7:0])})
    else $error("sext.b result wrong");

  sexth_value_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && valid_i && op == bmru_pkg::BMRU_SEXTH
      |=> result_o == {{48{$past(rs1_i[15])}}, $past(rs1_i[15:0])})
    else $error("sext.h result wrong");

  sh1add_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_SH1ADD |=> result_o == $past(rs2_i) + {$past(rs1_i[62:0]), 1'b0})
    else $error("sh1add result wrong");

  sh1uw_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_SH1ADDUW
      |=> result_o == $past(rs2_i) + {31'h0, $past(rs1_i[31:0]), 1'b0})
    else $error("sh1add.uw result wrong");

  sh2add_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_SH2ADD |=> result_o == $past(rs2_i) + {$past(rs1_i[61:0]), 2'h0})
    else $error("sh2add result wrong");

  sh2uw_sum_a: assert property (@(posedge clk_i) disable iff (rst_i)
    go && op == bmru_pkg::BMRU_SH2ADDUW
      |=> result_o == $past(rs2_i) + {30'h0, $past(rs1_i[31:0]), 2'h0})
    else $error("sh2add.uw result wrong");

  stage_timing_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i |=> (valid_o || illegal_o) == $past(valid_i) && !(valid_o && illegal_o))
    else $error("result not captured in one cycle");

  // 64-bit-only operations on a 32-bit base are refused
  word_base32_a: assert property (@(posedge clk_i) disable iff (rst_i)
    en_i && valid_i && base32_i && op inside {bmru_pkg::BMRU_ROLW, bmru_pkg::BMRU_RORIW,
      bmru_pkg::BMRU_RORW, bmru_pkg::BMRU_SH1ADDUW, bmru_pkg::BMRU_SH2ADDUW}
      |=> illegal_o && !valid_o)
    else $error("word op on 32-bit base not flagged");

  // a refused operation never shows a result
  illegal_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    illegal_o |-> result_o == bmru_pkg::ZERO_X && !valid_o)
    else $error("flagged op wrote a result");

endmodule // bmru_unit

// [bmru_regs.sv]
// Purpose: register file model that feeds the unit's operand ports
// Assumes: writes land on the rising edge, reads are combinational
// Notes: register zero reads as zero
`timescale 1ns/10ps
module bmru_regs (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [4:0] wa_i,
  input wire logic [63:0] wd_i,
  input wire logic [4:0] ra_i,
  input wire logic [4:0] rb_i,
  output logic [63:0] qa_o,
  output logic [63:0] qb_o
);
  logic [63:0] mem [32];
  // write port
  always_ff @(posedge clk_i) begin
    if (we_i) mem[wa_i] <= wd_i;
  end
  // read ports, register zero is hard zero
  assign qa_o = (ra_i == 5'h00) ? 64'h0 : mem[ra_i];
  assign qb_o = (rb_i == 5'h00) ? 64'h0 : mem[rb_i];
endmodule // bmru_regs

// [bitmanip_rotate_shadd_unit_test.sv]
// Purpose: self-checking bench for the rotate / sign-extend / shift-add unit
// Assumes: operands come from the register model, regs 1 and 2
// Notes: each op takes four edges: write rs1, write rs2, present the op, capture
`timescale 1ns/10ps
module bitmanip_rotate_shadd_unit_test;
  localparam logic [63:0] A = 64'h8123_4567_89AB_CDEF;
  localparam logic [63:0] B = 64'hFFFF_FFFF_FFFF_FFE5; // low 6 bits 37, low 5 bits 5
  logic clk_i, rst_i, en_i, base32_i, valid_i, we, valid_o, illegal_o;
  logic [3:0] op_i;
  logic [5:0] shamt_i;
  logic [4:0] wa;
  logic [63:0] wd, rs1, rs2, result_o;
  int miscompares, n_checks, cyc;
  bmru_regs u_regs (.clk_i(clk_i), .we_i(we), .wa_i(wa), .wd_i(wd), .ra_i(5'h01),
    .rb_i(5'h02), .qa_o(rs1), .qb_o(rs2));
  bmru_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .en_i(en_i), .base32_i(base32_i),
    .valid_i(valid_i), .op_i(op_i), .rs1_i(rs1), .rs2_i(rs2), .shamt_i(shamt_i),
    .result_o(result_o), .valid_o(valid_o), .illegal_o(illegal_o));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] sx(logic [31:0] w);
    return {{32{w[31]}}, w};
  endfunction
  function automatic logic [31:0] rr32(logic [31:0] w, logic [4:0] n);
    return (w >> n) | (w << (6'd32 - n));
  endfunction
  function automatic logic [63:0] rr64(logic [63:0] w, logic [5:0] n);
    return (w >> n) | (w << (7'd64 - n));
  endfunction
  task automatic chk64(logic [63:0] g, logic [63:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t result %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(logic g, logic e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, g, e);
    end
  endtask
  // load operands, present the op, look after the capture edge
  task automatic issue(logic [3:0] op, logic b32, logic [63:0] a, logic [63:0] b,
    logic [5:0] sh);
    @(posedge clk_i);
    valid_i <= 1'b0;
    we <= 1'b1;
    wa <= 5'h01;
    wd <= a;
    @(posedge clk_i);
    wa <= 5'h02;
    wd <= b;
    // rs2 lands at the next edge, so the op waits one cycle for it
    @(posedge clk_i);
    op_i <= op;
    base32_i <= b32;
    shamt_i <= sh;
    valid_i <= 1'b1;
    @(posedge clk_i);
    #1;
  endtask
  task automatic legal(logic [3:0] op, logic b32, logic [63:0] a, logic [63:0] b,
    logic [5:0] sh, logic [63:0] e);
    issue(op, b32, a, b, sh);
    chk64(result_o, e);
    chk1(valid_o, 1'b1);
    chk1(illegal_o, 1'b0);
  endtask
  // refused op: flagged, no valid, zero result
  task automatic refused(logic [3:0] op, logic b32, logic [63:0] a, logic [63:0] b,
    logic [5:0] sh);
    issue(op, b32, a, b, sh);
    chk1(illegal_o, 1'b1);
    chk1(valid_o, 1'b0);
    chk64(result_o, 64'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_rot;
    legal(4'h0, 1'b0, A, B, 6'h00, sx(rr32(A[31:0], 5'd27)));
    legal(4'h1, 1'b0, A, B, 6'h00, rr64(A, 6'd37));
    legal(4'h2, 1'b0, A, 64'h0, 6'h3F, rr64(A, 6'd63));
    legal(4'h3, 1'b0, A, 64'h0, 6'h01, sx(rr32(A[31:0], 5'd1)));
    legal(4'h4, 1'b0, A, B, 6'h00, sx(rr32(A[31:0], 5'd5)));
  endtask
  task automatic t_sext;
    legal(4'h5, 1'b0, 64'h1234_5678_9ABC_DE80, B, 6'h00, 64'hFFFF_FFFF_FFFF_FF80);
    legal(4'h5, 1'b0, 64'hFFFF_FFFF_FFFF_FF7F, B, 6'h00, 64'h7F);
    legal(4'h6, 1'b0, 64'h0000_0000_0001_8001, B, 6'h00, 64'hFFFF_FFFF_FFFF_8001);
    legal(4'h6, 1'b0, 64'hFFFF_FFFF_FFFF_7FFF, B, 6'h00, 64'h7FFF);
  endtask
  task automatic t_shadd;
    legal(4'h7, 1'b0, A, B, 6'h00, B + (A << 1));
    legal(4'h8, 1'b0, A, B, 6'h00, B + ({32'h0, A[31:0]} << 1));
    legal(4'h9, 1'b0, A, B, 6'h00, B + (A << 2));
    legal(4'hA, 1'b0, A, B, 6'h00, B + ({32'h0, A[31:0]} << 2));
  endtask
  // 32-bit base: short amounts, reserved immediate refused
  task automatic t_base32;
    legal(4'h1, 1'b1, A, B, 6'h00, sx(rr32(A[31:0], 5'd5)));
    legal(4'h2, 1'b1, A, 64'h0, 6'h1F, sx(rr32(A[31:0], 5'd31)));
    issue(4'h2, 1'b1, A, 64'h0, 6'h21);
    chk1(illegal_o, 1'b1);
    chk1(valid_o, 1'b0);
    chk64(result_o, 64'h0);
    refused(4'h0, 1'b1, A, B, 6'h00);
    refused(4'hB, 1'b0, A, B, 6'h00);
    legal(4'h7, 1'b1, A, B, 6'h00, sx(B[31:0] + (A[31:0] << 1)));
  endtask
  // result appears one edge after selection and holds while frozen
  task automatic t_timing;
    legal(4'h7, 1'b0, 64'h1, 64'h2, 6'h00, 64'h4);
    @(posedge clk_i);
    en_i <= 1'b0;
    valid_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk1(valid_o, 1'b1);
    chk64(result_o, 64'h4);
    @(posedge clk_i);
    en_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk1(valid_o, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 500) begin
      miscompares++;
      give_verdict();
    end
  end
  // main sequence
  initial begin
    {rst_i, en_i, base32_i, valid_i, we} = 5'b11001;
    {op_i, shamt_i, wa, wd} = '0;
    {miscompares, n_checks, cyc} = '0;
    // clear the two operand registers while reset is held
    @(posedge clk_i);
    wa <= 5'h01;
    @(posedge clk_i);
    wa <= 5'h02;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk1(valid_o, 1'b0);
    chk64(result_o, 64'h0);
    t_rot();
    t_sext();
    t_shadd();
    t_base32();
    t_timing();
    give_verdict();
  end
endmodule // bitmanip_rotate_shadd_unit_test
